// ==== hw/buck_startup_uvlo_sequencer.sv ====
// Start-up gating, lockout combination and output-voltage configuration.
// Assumes async comparator inputs, power-stage input level as 8-bit code.
// How it works
// - Control supply, rails and reset end open bus; rails loss after reset end does not stop switching
// - Control-good rise starts core; reset starts once rails also good
// - Drivers off until driver supply good
// - Turn-on threshold from 6-bit code
// - Turn-off threshold from own 6-bit code
// - Compare input against both thresholds separately
// - Enable pin ignorable or polarity inverted
// - Fixed reset interval before sensing inputs
// - Conditions met early start delay at end
// - Else delay starts when all four met
// - Timing from writable command values
// - Divider ratio only 1,2,4 or 8
// - Clamped output suppresses undervoltage alarms
// - Strap loads output settings during reset
// - Host writes replace strap values afterwards
// - Limits relative by default, absolute selectable
// - Configuration accepted only after rails and reset
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module buck_startup_uvlo_sequencer
    import seq_pkg::*;
#(
    parameter int PorCycles = POR_CYCLES
)(
    input  wire logic               mclk,
    input  wire logic               nrst,
    input  seq_pkg::supply_ind_t    supplyInd,
    input  wire logic [7:0]         powerStageLevel,
    input  wire logic [3:0]         voltageSelectStrap,
    input  wire logic [15:0]        voutSense,
    input  wire logic [7:0]         addr,
    input  wire logic [15:0]        wrData,
    input  wire logic               wrStb,
    input  wire logic               rdStb,
    output logic [15:0]             rdData,
    output logic                    busEnabled,
    output logic                    monitorEnabled,
    output logic                    driverEnable,
    output logic                    switchEnable,
    output logic                    tonActive,
    output logic [1:0]              dividerSel,
    output logic                    absoluteFormat,
    output logic                    uvWarn,
    output logic                    uvFault
);
    import seq_pkg::*;

    localparam int NIND = 4;

    // Power-stage level code is in 250 mV units above 0
    function automatic logic [7:0] thr(input logic [5:0] c, input int baseMv);
        return 8'((baseMv / VIN_STEP_MV) + int'(c));
    endfunction

    logic [2:0] syncR [NIND];
    logic [2:0] cntR  [NIND];
    logic [NIND-1:0] cleanR;
    logic [NIND-1:0] rawIn;
    assign rawIn = supplyInd;

    // Three-stage synchroniser then deglitch counter
    for (genvar i = 0; i < NIND; i++) begin : g_sync
        always_ff @(posedge mclk) begin
            if (!nrst) begin
                syncR[i]  <= 3'h0;
                cntR[i]   <= 3'h0;
                cleanR[i] <= 1'b0;
            end else begin
                syncR[i] <= {syncR[i][1:0], rawIn[i]};
                if (syncR[i][1] != syncR[i][2] || syncR[i][2] == cleanR[i]) begin
                    cntR[i] <= 3'h0;
                end else if (cntR[i] == 3'(DEGLITCH_CYCLES - 1)) begin
                    cntR[i]   <= 3'h0;
                    cleanR[i] <= syncR[i][2];
                end else begin
                    cntR[i] <= cntR[i] + 3'h1;
                end
            end
        end
    end

    logic ctrlGood, railsGood, drvGood, enPin;
    assign enPin     = cleanR[0];
    assign drvGood   = cleanR[1];
    assign railsGood = cleanR[2];
    assign ctrlGood  = cleanR[3];

    // Registers
    logic [7:0]  operationR, onOffR, voutModeR;
    logic [5:0]  vinOnR, vinOffR;
    logic [15:0] tonDelayR, tonRiseR, toffDelayR, toffFallR;
    logic [15:0] uvWarnLimR, uvFaultLimR;
    vout_set_t   voutR, strapData;
    seq_state_t  stateR;
    logic [31:0] porCntR;
    logic [15:0] tonCntR;
    logic        inputGoodR;
    logic        porDone;

    strap_table u_strap (
        .mclk (mclk),
        .code (voltageSelectStrap),
        .data (strapData)
    );

    assign porDone = (stateR == ST_WAIT) || (stateR == ST_TON_DELAY) || (stateR == ST_ON);

    logic cfgOpen;
    assign cfgOpen = porDone && ctrlGood && railsGood;

    // Input-good with separate on/off comparisons; may chatter if off > on
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            inputGoodR <= 1'b0;
        end else if (!porDone) begin
            inputGoodR <= 1'b0;
        end else if (!inputGoodR && powerStageLevel >= thr(vinOnR, VIN_ON_BASE_MV)) begin
            inputGoodR <= 1'b1;
        end else if (inputGoodR && powerStageLevel < thr(vinOffR, VIN_OFF_BASE_MV)) begin
            inputGoodR <= 1'b0;
        end
    end

    // Enable pin qualified by configuration
    logic pinOk, opOk, startOk;
    always_comb begin
        pinOk = !onOffR[CFG_PIN_USE_BIT] || (enPin ^ !onOffR[CFG_POL_BIT]);
        opOk  = operationR[OPER_ON_BIT];
    end
    assign startOk = drvGood && inputGoodR && pinOk && opOk;

    // Sequencer
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            stateR  <= ST_OFF;
            porCntR <= 32'h0;
            tonCntR <= 16'h0;
        end else begin
            unique case (stateR)
                ST_OFF: begin
                    porCntR <= 32'h0;
                    if (ctrlGood && railsGood) begin
                        stateR <= ST_POR;
                    end
                end
                ST_POR: begin
                    if (!ctrlGood) begin
                        stateR <= ST_OFF;
                    end else if (porCntR == 32'(PorCycles - 1)) begin
                        stateR <= ST_WAIT;
                    end else begin
                        porCntR <= porCntR + 32'h1;
                    end
                end
                ST_WAIT: begin
                    tonCntR <= 16'h0;
                    if (!ctrlGood) begin
                        stateR <= ST_OFF;
                    end else if (startOk) begin
                        stateR <= ST_TON_DELAY;
                    end
                end
                ST_TON_DELAY: begin
                    if (!ctrlGood) begin
                        stateR <= ST_OFF;
                    end else if (!startOk) begin
                        stateR <= ST_WAIT;
                    end else if (tonCntR >= tonDelayR) begin
                        stateR <= ST_ON;
                    end else begin
                        tonCntR <= tonCntR + 16'h1;
                    end
                end
                ST_ON: begin
                    if (!ctrlGood) begin
                        stateR <= ST_OFF;
                    end else if (!startOk) begin
                        stateR <= ST_WAIT;
                    end
                end
            endcase
        end
    end

    // Configuration registers
    // Strap load owns the reset interval; host writes only once bus opens
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            operationR  <= OPERATION_RST;
            onOffR      <= ONOFF_RST;
            voutModeR   <= VOUT_MODE_RST;
            vinOnR      <= VIN_ON_RST;
            vinOffR     <= VIN_OFF_RST;
            tonDelayR   <= TIME_RST;
            tonRiseR    <= TIME_RST;
            toffDelayR  <= TIME_RST;
            toffFallR   <= TIME_RST;
            uvWarnLimR  <= UV_WARN_RST;
            uvFaultLimR <= UV_FAULT_RST;
            voutR       <= '0;
        end else if (stateR == ST_POR) begin
            voutR <= strapData;
        end else if (wrStb && cfgOpen) begin
            unique case (addr)
                OFS_OPERATION:  operationR  <= wrData[7:0];
                OFS_ONOFF_CFG:  onOffR      <= wrData[7:0];
                OFS_VOUT_MODE:  voutModeR   <= wrData[7:0];
                OFS_VIN_ON:     vinOnR      <= wrData[5:0];
                OFS_VIN_OFF:    vinOffR     <= wrData[5:0];
                OFS_TON_DELAY:  tonDelayR   <= wrData;
                OFS_TON_RISE:   tonRiseR    <= wrData;
                OFS_TOFF_DELAY: toffDelayR  <= wrData;
                OFS_TOFF_FALL:  toffFallR   <= wrData;
                OFS_UV_WARN:    uvWarnLimR  <= wrData;
                OFS_UV_FAULT:   uvFaultLimR <= wrData;
                OFS_VOUT_CMD:   voutR.command <= wrData;
                OFS_VOUT_MIN:   voutR.vmin    <= wrData;
                OFS_VOUT_MAX:   voutR.vmax    <= wrData;
                OFS_VOUT_SCALE: voutR.scale   <= wrData[1:0];
                default: ;
            endcase
        end
    end

    // Reference clamp: achievable output window for the current scale
    logic [15:0] winLo, winHi, uvWarnAbs, uvFaultAbs;
    logic        clamped;
    always_comb begin
        winLo = 16'(REF_MIN_MV << voutR.scale);
        winHi = 16'(REF_MAX_MV << voutR.scale);
        clamped = (voutR.command < winLo) || (voutR.command > winHi);
        // Relative limits are per-mille of command; absolute are millivolts
        if (voutModeR[MODE_ABS_BIT]) begin
            uvWarnAbs  = uvWarnLimR;
            uvFaultAbs = uvFaultLimR;
        end else begin
            uvWarnAbs  = 16'((32'(voutR.command) * 32'(uvWarnLimR)) / 32'd1000);
            uvFaultAbs = 16'((32'(voutR.command) * 32'(uvFaultLimR)) / 32'd1000);
        end
    end

    // Outputs
    // Alarms only while on and reference not clamped
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            busEnabled     <= 1'b0;
            monitorEnabled <= 1'b0;
            driverEnable   <= 1'b0;
            switchEnable   <= 1'b0;
            tonActive      <= 1'b0;
            dividerSel     <= DIV_1;
            absoluteFormat <= 1'b0;
            uvWarn         <= 1'b0;
            uvFault        <= 1'b0;
        end else begin
            busEnabled     <= cfgOpen;
            monitorEnabled <= ctrlGood;
            driverEnable   <= drvGood && porDone;
            switchEnable   <= (stateR == ST_ON) && startOk;
            tonActive      <= stateR == ST_TON_DELAY;
            dividerSel     <= voutR.scale;
            absoluteFormat <= voutModeR[MODE_ABS_BIT];
            uvWarn         <= (stateR == ST_ON) && !clamped && voutSense < uvWarnAbs;
            uvFault        <= (stateR == ST_ON) && !clamped && voutSense < uvFaultAbs;
        end
    end

    // Read port
    // Data stand one cycle after the strobe, zero otherwise
    // Status: clamp, input good, clean inputs, reset done, on
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdData <= 16'h0;
        end else if (rdStb) begin
            unique case (addr)
                OFS_OPERATION:  rdData <= {8'h00, operationR};
                OFS_ONOFF_CFG:  rdData <= {8'h00, onOffR};
                OFS_VOUT_MODE:  rdData <= {8'h00, voutModeR};
                OFS_VIN_ON:     rdData <= {10'h000, vinOnR};
                OFS_VIN_OFF:    rdData <= {10'h000, vinOffR};
                OFS_TON_DELAY:  rdData <= tonDelayR;
                OFS_TON_RISE:   rdData <= tonRiseR;
                OFS_TOFF_DELAY: rdData <= toffDelayR;
                OFS_TOFF_FALL:  rdData <= toffFallR;
                OFS_UV_WARN:    rdData <= uvWarnLimR;
                OFS_UV_FAULT:   rdData <= uvFaultLimR;
                OFS_VOUT_CMD:   rdData <= voutR.command;
                OFS_VOUT_MIN:   rdData <= voutR.vmin;
                OFS_VOUT_MAX:   rdData <= voutR.vmax;
                OFS_VOUT_SCALE: rdData <= {14'h0, voutR.scale};
                OFS_STATUS:     rdData <= {8'h00, clamped, inputGoodR, cleanR,
                                           porDone, stateR == ST_ON};
                OFS_PSI_LEVEL:  rdData <= {8'h00, powerStageLevel};
                default:        rdData <= 16'h0000;
            endcase
        end else begin
            rdData <= 16'h0000;
        end
    end

endmodule

// ==== hw/seq_pkg.sv ====
// Package for the start-up gating and output-voltage configuration sequencer.
// Assumes a single 200 MHz clock and a plain register port on the host side.
package seq_pkg;

    // Register offsets (command codes)
    localparam logic [7:0] OFS_OPERATION  = 8'h01;
    localparam logic [7:0] OFS_ONOFF_CFG  = 8'h02;
    localparam logic [7:0] OFS_VOUT_MODE  = 8'h20;
    localparam logic [7:0] OFS_VOUT_CMD   = 8'h21;
    localparam logic [7:0] OFS_VOUT_MAX   = 8'h24;
    localparam logic [7:0] OFS_VOUT_SCALE = 8'h29;
    localparam logic [7:0] OFS_VOUT_MIN   = 8'h2b;
    localparam logic [7:0] OFS_UV_WARN    = 8'h43;
    localparam logic [7:0] OFS_UV_FAULT   = 8'h44;
    localparam logic [7:0] OFS_VIN_ON     = 8'h35;
    localparam logic [7:0] OFS_VIN_OFF    = 8'h36;
    localparam logic [7:0] OFS_TON_DELAY  = 8'h60;
    localparam logic [7:0] OFS_TON_RISE   = 8'h61;
    localparam logic [7:0] OFS_TOFF_DELAY = 8'h64;
    localparam logic [7:0] OFS_TOFF_FALL  = 8'h65;
    localparam logic [7:0] OFS_STATUS     = 8'hd0;
    localparam logic [7:0] OFS_PSI_LEVEL  = 8'hd1;

    // Field positions
    localparam int OPER_ON_BIT     = 7;
    localparam int CFG_PIN_USE_BIT = 2;
    localparam int CFG_POL_BIT     = 1;
    localparam int MODE_ABS_BIT    = 7;

    // Reset values
    localparam logic [7:0]  OPERATION_RST = 8'h00;
    localparam logic [7:0]  ONOFF_RST     = 8'h16;
    localparam logic [7:0]  VOUT_MODE_RST = 8'h00;
    localparam logic [5:0]  VIN_ON_RST    = 6'h06;
    localparam logic [5:0]  VIN_OFF_RST   = 6'h04;
    localparam logic [15:0] TIME_RST      = 16'h0000;
    localparam logic [15:0] UV_WARN_RST   = 16'h0000;
    localparam logic [15:0] UV_FAULT_RST  = 16'h0000;

    // Threshold decode: millivolts, 250 mV steps
    localparam int VIN_STEP_MV    = 250;
    localparam int VIN_ON_BASE_MV = 2750;
    localparam int VIN_OFF_BASE_MV = 2500;

    // Divider codes and per-scale reference window in millivolts of output
    localparam logic [1:0] DIV_1 = 2'd0;
    localparam logic [1:0] DIV_2 = 2'd1;
    localparam logic [1:0] DIV_4 = 2'd2;
    localparam logic [1:0] DIV_8 = 2'd3;
    localparam int REF_MIN_MV = 250;
    localparam int REF_MAX_MV = 750;

    // Timing
    localparam int CLK_MHZ        = 200;
    localparam int POR_TIME_MS    = 6;
    localparam int POR_CYCLES     = POR_TIME_MS * 1000 * CLK_MHZ;
    localparam int DEGLITCH_CYCLES = 4;
    localparam int STRAP_ENTRIES  = 16;

    typedef enum {
        ST_OFF,
        ST_POR,
        ST_WAIT,
        ST_TON_DELAY,
        ST_ON
    } seq_state_t;

    // Strap-loaded output-voltage settings
    typedef struct packed {
        logic [1:0]  scale;
        logic [15:0] command;
        logic [15:0] vmin;
        logic [15:0] vmax;
    } vout_set_t;

    // Raw comparator indications
    typedef struct packed {
        logic ctrlSupplyGood;
        logic coreRailsGood;
        logic driverSupplyGood;
        logic enablePin;
    } supply_ind_t;

endpackage

// ==== hw/strap_table.sv ====
// Strap decode table: voltage-select strap code to output settings.
// Assumes the code is stable while it is read; data come from a register.
`timescale 1ns/100ps
module strap_table
    import seq_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic [3:0] code,
    output seq_pkg::vout_set_t data
);

    function automatic vout_set_t entry(input logic [3:0] c);
        vout_set_t e;
        logic [15:0] mv;
        mv = 16'(500 + 16'(c) * 16'd333);
        e.scale = (mv <= 16'd750) ? DIV_1 : (mv <= 16'd1500) ? DIV_2 :
                  (mv <= 16'd3000) ? DIV_4 : DIV_8;
        e.command = mv;
        e.vmin = 16'(mv >> 1);
        e.vmax = 16'(mv + (mv >> 2));
        return e;
    endfunction

    always_ff @(posedge mclk) begin
        data <= entry(code);
    end

endmodule

// ==== tb/host_model.sv ====
// Host-side register master model for the sequencer bench.
// Assumes the plain strobe port and one shared clock.
`timescale 1ns/100ps
module host_model (
    input  wire logic        mclk,
    output logic [7:0]       addr,
    output logic [15:0]      wrData,
    output logic             wrStb,
    output logic             rdStb,
    input  wire logic [15:0] rdData
);
    initial begin
        {addr, wrData, wrStb, rdStb} = '0;
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'h1;
        @(posedge mclk);
        wrStb <= 1'h0;
        addr <= ~a;
        wrData <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        rdStb <= 1'h1;
        @(posedge mclk);
        rdStb <= 1'h0;
        addr <= ~a;
        @(negedge mclk);
        d = rdData;
    endtask
endmodule

// ==== tb/seq_assertions.sv ====
// Port checker for the start-up sequencer.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module seq_assertions
    import seq_pkg::*;
(
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic [7:0]  addr,
    input wire logic        wrStb,
    input wire logic        rdStb,
    input wire logic [15:0] rdData,
    input wire logic        busEnabled,
    input wire logic        monitorEnabled,
    input wire logic        driverEnable,
    input wire logic        switchEnable,
    input wire logic        tonActive,
    input wire logic [1:0]  dividerSel,
    input wire logic        absoluteFormat
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire logic modeWr  = wrStb && addr == OFS_VOUT_MODE;
    wire logic scaleWr = wrStb && addr == OFS_VOUT_SCALE;

    property p_resetOff;
        disable iff (1'h0) !nrst |=> !switchEnable && !driverEnable && !busEnabled;
    endproperty
    a_resetOff: assert property (p_resetOff) else $error("output active in reset");
    property p_swDrv;
        switchEnable |-> driverEnable;
    endproperty
    a_swDrv: assert property (p_swDrv) else $error("switching without drivers");
    property p_swBus;
        switchEnable |-> busEnabled && monitorEnabled;
    endproperty
    a_swBus: assert property (p_swBus) else $error("switching before reset end");
    property p_busMon;
        busEnabled |-> monitorEnabled;
    endproperty
    a_busMon: assert property (p_busMon) else $error("bus open without supply");
    property p_tonFirst;
        $rose(switchEnable) |-> $past(tonActive) || $past(tonActive, 2);
    endproperty
    a_tonFirst: assert property (p_tonFirst) else $error("switching skipped delay");
    property p_rdIdle;
        !$past(rdStb) |-> rdData == 16'h0000;
    endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("read data outside slot");
    property p_modeWr;
        $changed(absoluteFormat) |-> $past(modeWr) || $past(modeWr, 2);
    endproperty
    a_modeWr: assert property (p_modeWr) else $error("format changed unasked");
    property p_scaleWr;
        $changed(dividerSel) |-> !$past(busEnabled) || $past(scaleWr) || $past(scaleWr, 2);
    endproperty
    a_scaleWr: assert property (p_scaleWr) else $error("divider changed unasked");
    property p_refused;
        !busEnabled && modeWr |=> ##1 $stable(absoluteFormat);
    endproperty
    a_refused: assert property (p_refused) else $error("early write accepted");
    c_on: cover property ($rose(switchEnable));
    c_ton: cover property ($rose(tonActive));
    c_scale: cover property (busEnabled && scaleWr);
endmodule

// ==== tb/buck_startup_uvlo_sequencer_tb.sv ====
// Self-checking bench for the start-up sequencer.
// Assumes host model and checker are compiled before this file.
`timescale 1ns/100ps
module buck_startup_uvlo_sequencer_tb;
    import seq_pkg::*;
    localparam int Por = 20;
    logic        mclk;
    logic        nrst;
    supply_ind_t supplyInd;
    logic [7:0]  lvl;
    logic [7:0]  addr;
    logic [15:0] wrData;
    logic        wrStb;
    logic        rdStb;
    logic [15:0] rdData;
    logic        busEn;
    logic        monEn;
    logic        drvEn;
    logic        swEn;
    logic        tonAct;
    logic [1:0]  divSel;
    logic        absFmt;
    logic [15:0] rv;
    logic [15:0] vs;
    logic        uvW;
    logic        uvF;
    int          nFail = 0;
    int          nChecks = 0;
    int          cyc = 0;
    int          n;

    buck_startup_uvlo_sequencer #(.PorCycles(Por)) dut_u (
        .mclk(mclk), .nrst(nrst), .supplyInd(supplyInd), .powerStageLevel(lvl),
        .voltageSelectStrap(4'h3), .voutSense(vs), .addr(addr), .wrData(wrData),
        .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .busEnabled(busEn),
        .monitorEnabled(monEn), .driverEnable(drvEn), .switchEnable(swEn),
        .tonActive(tonAct), .dividerSel(divSel), .absoluteFormat(absFmt),
        .uvWarn(uvW), .uvFault(uvF));
    host_model hostU (.mclk(mclk), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData));

    task automatic check(input string what, input logic [15:0] exp, got);
        nChecks++;
        if (got !== exp) begin
            nFail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic waitFor(ref logic s, input logic v, input int lim, input string what,
                           output int k);
        k = 0;
        while (s !== v && k < lim) begin
            @(negedge mclk);
            k++;
        end
        check(what, 16'(v), 16'(s));
    endtask

    task automatic tStrap();
        hostU.wr(OFS_VOUT_MODE, 16'h0080);
        waitFor(busEn, 1'h1, Por + 40, "busEnabled", n);
        check("porLen", 16'h0001, 16'(n >= Por - 3));
        check("monOn", 16'h0001, 16'(monEn));
        hostU.rd(OFS_VOUT_MODE, rv);
        check("modeEarly", 16'h0000, rv);
        hostU.rd(OFS_VOUT_CMD, rv);
        check("strapCmd", 16'h05db, rv);
        hostU.rd(OFS_ONOFF_CFG, rv);
        check("onoffRst", 16'h0016, rv);
        hostU.rd(OFS_VIN_ON, rv);
        check("vinOnRst", 16'h0006, rv);
        hostU.rd(8'h7f, rv);
        check("unmapped", 16'h0000, rv);
        hostU.rd(OFS_PSI_LEVEL, rv);
        check("level", 16'h000a, rv);
        check("tonIdle", 16'h0000, 16'(tonAct));
        $display("tStrap done");
    endtask

    task automatic tStart();
        hostU.wr(OFS_TON_DELAY, 16'h0005);
        hostU.wr(OFS_OPERATION, 16'h0080);
        repeat (30) @(negedge mclk);
        check("tonBelowOn", 16'h0000, 16'(tonAct));
        @(posedge mclk) lvl <= 8'h14;
        waitFor(tonAct, 1'h1, 20, "tonStart", n);
        waitFor(swEn, 1'h1, 20, "switchOn", n);
        check("tonLen", 16'h0001, 16'(n >= 5 && n <= 8));
        $display("tStart done");
    endtask

    task automatic tLevel();
        logic last;
        @(posedge mclk) lvl <= 8'h0c;
        waitFor(swEn, 1'h0, 20, "offBelowOff", n);
        @(posedge mclk) lvl <= 8'h10;
        repeat (30) @(negedge mclk);
        check("hyst", 16'h0000, 16'(swEn));
        hostU.wr(OFS_VIN_ON, 16'h0014);
        @(posedge mclk) lvl <= 8'h19;
        repeat (30) @(negedge mclk);
        check("onRaised", 16'h0000, 16'(swEn));
        hostU.wr(OFS_VIN_ON, 16'h0006);
        waitFor(swEn, 1'h1, 30, "onAgain", n);
        hostU.wr(OFS_VIN_OFF, 16'h001e);
        n = 0;
        last = tonAct;
        repeat (100) begin
            @(negedge mclk);
            n += int'(tonAct != last);
            last = tonAct;
        end
        check("toggles", 16'h0001, 16'(n >= 2));
        hostU.wr(OFS_VIN_OFF, 16'h0004);
        waitFor(swEn, 1'h1, 30, "offRestored", n);
        $display("tLevel done");
    endtask

    task automatic tPin();
        @(posedge mclk) supplyInd.enablePin <= 1'h0;
        waitFor(swEn, 1'h0, 30, "pinOff", n);
        hostU.wr(OFS_ONOFF_CFG, 16'h0014);
        waitFor(swEn, 1'h1, 30, "pinLow", n);
        hostU.wr(OFS_ONOFF_CFG, 16'h0010);
        @(posedge mclk) supplyInd.enablePin <= 1'h1;
        repeat (30) @(negedge mclk);
        check("pinIgnored", 16'h0001, 16'(swEn));
        $display("tPin done");
    endtask

    task automatic tFmt();
        for (int i = 0; i < 4; i++) begin
            hostU.wr(OFS_VOUT_SCALE, 16'(i));
            repeat (2) @(negedge mclk);
            check("divider", 16'(i), 16'(divSel));
        end
        hostU.wr(OFS_VOUT_CMD, 16'h0bb8);
        hostU.rd(OFS_VOUT_CMD, rv);
        check("cmdWrite", 16'h0bb8, rv);
        hostU.wr(OFS_VOUT_MODE, 16'h0080);
        repeat (2) @(negedge mclk);
        check("absFmt", 16'h0001, 16'(absFmt));
        $display("tFmt done");
    endtask

    task automatic tUv();
        @(posedge mclk) vs <= 16'h09c4;
        hostU.wr(OFS_VOUT_MODE, 16'h0000);
        hostU.wr(OFS_UV_WARN, 16'h0384);
        hostU.wr(OFS_UV_FAULT, 16'h0320);
        repeat (3) @(negedge mclk);
        check("uvWarnRel", 16'h0001, 16'(uvW));
        check("uvFaultRel", 16'h0000, 16'(uvF));
        hostU.wr(OFS_VOUT_MODE, 16'h0080);
        repeat (3) @(negedge mclk);
        check("uvWarnAbs", 16'h0000, 16'(uvW));
        @(posedge mclk) vs <= 16'h02bc;
        repeat (3) @(negedge mclk);
        check("uvFaultAbs", 16'h0001, 16'(uvF));
        hostU.wr(OFS_VOUT_SCALE, 16'h0000);
        repeat (3) @(negedge mclk);
        check("uvClamped", 16'h0000, 16'(uvF));
        $display("tUv done");
    endtask

    task automatic tSupply();
        @(posedge mclk) supplyInd.driverSupplyGood <= 1'h0;
        waitFor(drvEn, 1'h0, 20, "drvOff", n);
        check("swDrvOff", 16'h0000, 16'(swEn));
        @(posedge mclk) supplyInd.coreRailsGood <= 1'h0;
        waitFor(busEn, 1'h0, 20, "busOff", n);
        check("monHeld", 16'h0001, 16'(monEn));
        @(posedge mclk) supplyInd.ctrlSupplyGood <= 1'h0;
        waitFor(monEn, 1'h0, 20, "monOff", n);
        $display("tSupply done");
    endtask

    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", nChecks, nFail);
        if (nFail == 0 && nChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            nFail++;
            tallyAndFinish();
        end
    end

    initial begin
        nrst = 1'h0;
        supplyInd = '1;
        lvl = 8'h0a;
        vs = 16'h0000;
        repeat (20) @(posedge mclk);
        nrst <= 1'h1;
        tStrap();
        tStart();
        tLevel();
        tPin();
        tFmt();
        tUv();
        tSupply();
        tallyAndFinish();
    end
endmodule

bind buck_startup_uvlo_sequencer seq_assertions chk_u (
    .mclk(mclk), .nrst(nrst), .addr(addr), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .busEnabled(busEnabled), .monitorEnabled(monitorEnabled), .driverEnable(driverEnable),
    .switchEnable(switchEnable), .tonActive(tonActive), .dividerSel(dividerSel),
    .absoluteFormat(absoluteFormat));
